// >>> rtl/pwr_consts.svh
// timing counts and field codes for the power mode controller
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH
`define STARTUP_TIME_US     100
`define SYS_CLK_MHZ         10
`define STARTUP_CYCLES      (`STARTUP_TIME_US * `SYS_CLK_MHZ)
`define STARTUP_CNT_W       10
`define DIV_SLOW_A          3'h0
`define DIV_SLOW_B          3'h1
`define NUM_PORT_PINS       8
`define NUM_IRQ             8
`endif

// >>> rtl/pwr_pkg.sv
// types for the power mode controller
package pwr_pkg;
    typedef enum logic [2:0] {
        NORMAL_RUN,
        SLOW_RUN,
        DEEP_SLEEP_STATE,
        SLEEP_WITH_SUBCLOCK_STATE,
        IDLE_SUBCLOCK_ONLY_STATE,
        IDLE_FULL_CLOCK_STATE,
        FAST_STARTUP
    } mode_t;

    typedef enum logic [1:0] {
        OSC_IDLE,
        OSC_FAST,
        OSC_SLOW
    } sst_phase_t;
endpackage

// >>> rtl/power_mode_wakeup_control.sv
// operating mode, halt state and wake-up controller
`timescale 1ns/1ps
`include "pwr_consts.svh"

// What this block does
// - fast select 0, divider 000/001 gives slow
// - fast select 1 or divider 010+ gives normal
// - slow clock chosen stops fast oscillator, dividers
// - slow switch waits for slow oscillator ready
// - report fast ready when returning to normal
// - halt, no idle, no wdt/lvd: deep sleep
// - halt, idle, keep bit 0: subclock idle
// - halt, idle, keep bit 1: full idle
// - entering low power sets pdf, clears timeout
// - light states clear watchdog, keep counting
// - wake on reset, port edge, irq, overflow
// - reset wake full reset, overflow watchdog reset
// - pdf set halt, cleared clear-wdt; timeout flag
// - per pin falling edge wake, resume after halt
// - disabled or stack full irq stays pending
// - enabled irq with stack room is serviced
// - irq already pending at halt cannot wake
// - shared startup timer, slow after fast
// - after deep sleep run only once fast ready
// - peripherals follow system clock source
// - slow clock runs whenever watchdog enabled
// - keep bit resets to 0
module power_mode_wakeup_control
    import pwr_pkg::*;
(
    input  wire logic                        SYS_CLK,
    input  wire logic                        RST,
    input  wire logic                        FAST_CLOCK_SELECT,
    input  wire logic [2:0]                  CLOCK_DIVIDER_SELECT,
    input  wire logic                        IDLE_ON_HALT_ENABLE,
    input  wire logic                        SYSCLK_KEEP_IN_IDLE,
    input  wire logic                        WATCHDOG_ENABLE,
    input  wire logic                        LVD_ENABLE,
    input  wire logic                        HALT_INSTR,
    input  wire logic                        WATCHDOG_CLEAR_INSTR,
    input  wire logic                        WATCHDOG_OVERFLOW,
    input  wire logic                        EXT_RESET_REQ,
    input  wire logic [`NUM_PORT_PINS-1:0]   PORT_PINS,
    input  wire logic [`NUM_PORT_PINS-1:0]   PORT_WAKE_ENABLE,
    input  wire logic [`NUM_IRQ-1:0]         IRQ_FLAGS,
    input  wire logic [`NUM_IRQ-1:0]         IRQ_ENABLES,
    input  wire logic                        STACK_FULL,
    output logic                             FAST_OSC_RUN,
    output logic                             FAST_DIV_RUN,
    output logic                             SLOW_OSC_RUN,
    output logic                             SYSCLK_FROM_SLOW,
    output logic                             SYSCLK_RUN,
    output logic                             SUBCLK_RUN,
    output logic                             CPU_RUN,
    output logic                             FAST_OSC_READY,
    output logic                             SLOW_OSC_READY,
    output logic                             POWER_DOWN_FLAG,
    output logic                             WATCHDOG_TIMEOUT_FLAG,
    output logic                             WATCHDOG_CLEAR,
    output logic                             WATCHDOG_STOP,
    output logic                             FULL_RESET,
    output logic                             WATCHDOG_RESET,
    output logic                             IRQ_SERVICE,
    output logic [2:0]                       MODE_STATE
);

    // all state of the block except the registered outputs in one packed record
    typedef struct packed {
        mode_t                          mode;       // operating mode
        mode_t                          resume;     // mode to return to
        sst_phase_t                     oscillator_startup_timer;        // startup timer owner
        logic [`STARTUP_CNT_W-1:0]      sst_cnt;    // shared startup count
        logic                           fast_rdy;   // fast oscillator stable
        logic                           slow_rdy;   // slow oscillator stable
        logic                           power_down_flag;        // power down flag
        logic                           tof;        // watchdog timeout flag
        logic                           wdt_clr;    // watchdog clear pulse
        logic                           full_rst;   // full reset pulse
        logic                           wdt_rst;    // watchdog reset pulse
        logic                           irq_svc;    // service request pulse
        logic [`NUM_IRQ-1:0]            irq_mask;   // flags set at halt
        logic [`NUM_PORT_PINS-1:0]      pin_s1;     // pin sync stage one
        logic [`NUM_PORT_PINS-1:0]      pin_s2;     // pin sync stage two
        logic [`NUM_PORT_PINS-1:0]      pin_s3;     // previous synced level
        logic                           ext_s1;     // reset sync stage one
        logic                           ext_s2;     // reset sync stage two
    } state_t;

    state_t s_q;  // registered state
    state_t s_d;  // next state

    // requested run mode from the mode select bits
    function automatic logic wants_slow(input logic fsel,
                                        input logic [2:0] div);
        wants_slow = !fsel && (div == `DIV_SLOW_A ||
                               div == `DIV_SLOW_B);
    endfunction

    // true in any of the four halt states
    function automatic logic is_low_power(input mode_t m);
        is_low_power = (m == DEEP_SLEEP_STATE) ||
                       (m == SLEEP_WITH_SUBCLOCK_STATE) ||
                       (m == IDLE_SUBCLOCK_ONLY_STATE) ||
                       (m == IDLE_FULL_CLOCK_STATE);
    endfunction

    logic [`NUM_PORT_PINS-1:0] pin_fall;   // qualified falling edges
    logic [`NUM_IRQ-1:0]       irq_wake;   // irqs able to wake
    logic                      any_wake;   // a non-reset wake source

    // per pin falling edge detection on synced levels
    genvar g;
    generate
        for (g = 0; g < `NUM_PORT_PINS; g = g + 1) begin : g_pin
            assign pin_fall[g] = PORT_WAKE_ENABLE[g] && s_q.pin_s3[g] &&
                                 !s_q.pin_s2[g];
        end
    endgenerate

    // flags already pending at halt are masked from waking
    assign irq_wake = IRQ_FLAGS & ~s_q.irq_mask;
    assign any_wake = (|pin_fall) || (|irq_wake);

    // next state logic
    always_comb begin
        s_d          = s_q;
        s_d.wdt_clr  = 1'b0;
        s_d.full_rst = 1'b0;
        s_d.wdt_rst  = 1'b0;
        s_d.irq_svc  = 1'b0;
        s_d.pin_s1   = PORT_PINS;
        s_d.pin_s2   = s_q.pin_s1;
        s_d.pin_s3   = s_q.pin_s2;
        s_d.ext_s1   = EXT_RESET_REQ;
        s_d.ext_s2   = s_q.ext_s1;

        // shared startup timer: fast first, slow after
        case (s_q.oscillator_startup_timer)
            OSC_FAST: begin
                if (s_q.sst_cnt == `STARTUP_CNT_W'(`STARTUP_CYCLES - 1))
                begin
                    s_d.sst_cnt  = '0;
                    s_d.fast_rdy = 1'b1;
                    s_d.oscillator_startup_timer      = s_q.slow_rdy ? OSC_IDLE
                                                : OSC_SLOW;
                end else begin
                    s_d.sst_cnt = s_q.sst_cnt + 1'b1;
                end
            end
            OSC_SLOW: begin
                if (s_q.sst_cnt == `STARTUP_CNT_W'(`STARTUP_CYCLES - 1))
                begin
                    s_d.sst_cnt  = '0;
                    s_d.slow_rdy = 1'b1;
                    s_d.oscillator_startup_timer      = OSC_IDLE;
                end else begin
                    s_d.sst_cnt = s_q.sst_cnt + 1'b1;
                end
            end
            default: begin
                s_d.sst_cnt = '0;
                // slow needs its own run once the fast one is up
                if (!s_q.slow_rdy && s_q.fast_rdy)
                    s_d.oscillator_startup_timer = OSC_SLOW;
            end
        endcase

        // clear-wdt instruction drops pdf; halt sets it and wins
        if (WATCHDOG_CLEAR_INSTR) begin
            s_d.power_down_flag     = 1'b0;
            s_d.wdt_clr = 1'b1;
        end

        case (s_q.mode)
            NORMAL_RUN, SLOW_RUN: begin
                if (HALT_INSTR) begin
                    s_d.resume   = s_q.mode;
                    s_d.power_down_flag      = 1'b1;
                    s_d.tof      = 1'b0;
                    s_d.wdt_clr  = 1'b1;
                    s_d.irq_mask = IRQ_FLAGS;
                    if (!IDLE_ON_HALT_ENABLE) begin
                        if (WATCHDOG_ENABLE || LVD_ENABLE)
                            s_d.mode = SLEEP_WITH_SUBCLOCK_STATE;
                        else
                            s_d.mode = DEEP_SLEEP_STATE;
                    end else if (!SYSCLK_KEEP_IN_IDLE) begin
                        s_d.mode = IDLE_SUBCLOCK_ONLY_STATE;
                    end else begin
                        s_d.mode = IDLE_FULL_CLOCK_STATE;
                    end
                end else if (wants_slow(FAST_CLOCK_SELECT,
                                        CLOCK_DIVIDER_SELECT)) begin
                    // switch only with a stable slow oscillator
                    if (s_q.slow_rdy)
                        s_d.mode = SLOW_RUN;
                end else if (s_q.mode == SLOW_RUN) begin
                    // fast oscillator restarts before use
                    s_d.mode = s_q.fast_rdy ? NORMAL_RUN
                                            : FAST_STARTUP;
                end
            end
            FAST_STARTUP: begin
                // first instruction only once fast ready reads 1
                if (s_q.fast_rdy)
                    s_d.mode = NORMAL_RUN;
            end
            DEEP_SLEEP_STATE, SLEEP_WITH_SUBCLOCK_STATE,
            IDLE_SUBCLOCK_ONLY_STATE, IDLE_FULL_CLOCK_STATE: begin
                if (s_q.ext_s2) begin
                    s_d.full_rst = 1'b1;
                    s_d.mode     = FAST_STARTUP;
                end else if (WATCHDOG_OVERFLOW) begin
                    s_d.tof      = 1'b1;
                    s_d.wdt_rst  = 1'b1;
                    s_d.mode     = s_q.resume;
                end else if (any_wake) begin
                    // enabled irq with stack room gets serviced
                    s_d.irq_svc = |(irq_wake & IRQ_ENABLES) &&
                                  !STACK_FULL;
                    s_d.mode    = s_q.resume;
                end
                // deep sleep lost the fast clock: restart it
                if (s_d.mode == NORMAL_RUN && !s_q.fast_rdy)
                    s_d.mode = FAST_STARTUP;
                if (s_d.mode == SLOW_RUN && !s_q.slow_rdy)
                    s_d.mode = FAST_STARTUP;
            end
            default: s_d.mode = NORMAL_RUN;
        endcase

        // fast oscillator stops in slow run and deep sleep
        if (s_d.mode == SLOW_RUN || s_d.mode == DEEP_SLEEP_STATE) begin
            s_d.fast_rdy = 1'b0;
            if (s_q.oscillator_startup_timer == OSC_FAST)
                s_d.oscillator_startup_timer = OSC_IDLE;
        end else if (!s_q.fast_rdy && s_q.oscillator_startup_timer != OSC_FAST) begin
            s_d.oscillator_startup_timer     = OSC_FAST;
            s_d.sst_cnt = '0;
        end

        // slow oscillator stops only if nothing needs it
        if (!WATCHDOG_ENABLE && !LVD_ENABLE &&
            s_d.mode == DEEP_SLEEP_STATE) begin
            s_d.slow_rdy = 1'b0;
            if (s_q.oscillator_startup_timer == OSC_SLOW)
                s_d.oscillator_startup_timer = OSC_IDLE;
        end
    end

    // state register, synchronous reset
    // power-up waits out the fast startup before the core may run
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            s_q <= '{mode: FAST_STARTUP, resume: NORMAL_RUN,
                     oscillator_startup_timer: OSC_FAST, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs registered from next state
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            FAST_OSC_RUN          <= 1'b1;
            FAST_DIV_RUN          <= 1'b1;
            SLOW_OSC_RUN          <= 1'b1;
            SYSCLK_FROM_SLOW      <= 1'b0;
            SYSCLK_RUN            <= 1'b1;
            SUBCLK_RUN            <= 1'b1;
            CPU_RUN               <= 1'b0;
            FAST_OSC_READY        <= 1'b0;
            SLOW_OSC_READY        <= 1'b0;
            POWER_DOWN_FLAG       <= 1'b0;
            WATCHDOG_TIMEOUT_FLAG <= 1'b0;
            WATCHDOG_CLEAR        <= 1'b0;
            WATCHDOG_STOP         <= 1'b0;
            FULL_RESET            <= 1'b0;
            WATCHDOG_RESET        <= 1'b0;
            IRQ_SERVICE           <= 1'b0;
            MODE_STATE            <= 3'h0;
        end else begin
            FAST_OSC_RUN     <= !(s_d.mode == SLOW_RUN ||
                                  s_d.mode == DEEP_SLEEP_STATE);
            FAST_DIV_RUN     <= !(s_d.mode == SLOW_RUN ||
                                  s_d.mode == DEEP_SLEEP_STATE);
            SLOW_OSC_RUN     <= WATCHDOG_ENABLE || LVD_ENABLE ||
                                s_d.mode != DEEP_SLEEP_STATE;
            SYSCLK_FROM_SLOW <= (s_d.mode == SLOW_RUN);
            SYSCLK_RUN       <= !is_low_power(s_d.mode) ||
                                s_d.mode == IDLE_FULL_CLOCK_STATE;
            SUBCLK_RUN       <= s_d.mode != DEEP_SLEEP_STATE;
            CPU_RUN          <= s_d.mode == NORMAL_RUN ||
                                s_d.mode == SLOW_RUN;
            FAST_OSC_READY   <= s_d.fast_rdy;
            SLOW_OSC_READY   <= s_d.slow_rdy;
            POWER_DOWN_FLAG  <= s_d.power_down_flag;
            WATCHDOG_TIMEOUT_FLAG <= s_d.tof;
            WATCHDOG_CLEAR   <= s_d.wdt_clr;
            WATCHDOG_STOP    <= s_d.mode == DEEP_SLEEP_STATE;
            FULL_RESET       <= s_d.full_rst;
            WATCHDOG_RESET   <= s_d.wdt_rst;
            IRQ_SERVICE      <= s_d.irq_svc;
            MODE_STATE       <= s_d.mode;
        end
    end

endmodule

// >>> dv/cpu_core_model.sv
// core model that issues halt and clear-watchdog instruction pulses
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic clk,
    input  wire logic cpu_run,
    input  wire logic halt_req,
    input  wire logic clr_req,
    output logic      halt_q,
    output logic      clr_q
);
    // a stopped core executes nothing, so requests are dropped then
    always_ff @(posedge clk) begin
        halt_q <= halt_req & cpu_run;
        clr_q  <= clr_req & cpu_run;
    end
endmodule

// >>> dv/pmw_checker.sv
// port-level assertions for the power mode controller
`timescale 1ns/1ps
module pmw_checker
    import pwr_pkg::*;
(
    input wire logic       SYS_CLK, RST, HALT_INSTR, WATCHDOG_CLEAR_INSTR,
    input wire logic       WATCHDOG_OVERFLOW, IDLE_ON_HALT_ENABLE,
    input wire logic       SYSCLK_KEEP_IN_IDLE, WATCHDOG_ENABLE, LVD_ENABLE,
    input wire logic       CPU_RUN, SYSCLK_RUN, SUBCLK_RUN, SYSCLK_FROM_SLOW,
    input wire logic       FAST_OSC_RUN, FAST_DIV_RUN, SLOW_OSC_RUN,
    input wire logic       FAST_OSC_READY, SLOW_OSC_READY, POWER_DOWN_FLAG,
    input wire logic       WATCHDOG_TIMEOUT_FLAG, WATCHDOG_CLEAR,
    input wire logic       WATCHDOG_STOP, WATCHDOG_RESET,
    input wire logic       EXT_RESET_REQ,
    input wire logic [2:0] MODE_STATE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // halt only counts while the core runs in normal or slow mode
    wire logic halt_ok = HALT_INSTR && CPU_RUN && MODE_STATE < 3'h2;
    wire logic idl     = IDLE_ON_HALT_ENABLE;
    wire logic asleep  = MODE_STATE > 3'h1 && MODE_STATE < 3'h6;
    a_deep_sleep_entry: assert property (
        halt_ok && !idl && !WATCHDOG_ENABLE
        && !LVD_ENABLE |=> MODE_STATE == DEEP_SLEEP_STATE && !SYSCLK_RUN
        && WATCHDOG_CLEAR && WATCHDOG_STOP && POWER_DOWN_FLAG
        && !WATCHDOG_TIMEOUT_FLAG) else $error("deep sleep entry wrong");
    a_sub_sleep_entry: assert property (halt_ok && !idl
        && (WATCHDOG_ENABLE || LVD_ENABLE) |=> MODE_STATE == 3'h3
        && !SYSCLK_RUN && SUBCLK_RUN) else $error("sub sleep entry wrong");
    a_idle_sub_entry: assert property (
        halt_ok && idl && !SYSCLK_KEEP_IN_IDLE
        |=> MODE_STATE == 3'h4 && !SYSCLK_RUN && SUBCLK_RUN && !CPU_RUN)
        else $error("sub idle entry wrong");
    a_idle_full_entry: assert property (
        halt_ok && idl && SYSCLK_KEEP_IN_IDLE
        |=> MODE_STATE == 3'h5 && SYSCLK_RUN && SUBCLK_RUN && !CPU_RUN)
        else $error("full idle entry wrong");
    a_light_wdt_clear: assert property (halt_ok
        && (idl || WATCHDOG_ENABLE || LVD_ENABLE) |=> WATCHDOG_CLEAR
        && (!WATCHDOG_ENABLE || !WATCHDOG_STOP)) else $error("wdt not kept");
    a_slow_stops_fast: assert property (SYSCLK_FROM_SLOW |->
        !FAST_OSC_RUN && !FAST_DIV_RUN) else $error("fast osc runs in slow");
    a_slow_waits_ready: assert property ($rose(SYSCLK_FROM_SLOW)
        |-> SLOW_OSC_READY) else $error("slow switch before ready");
    a_wdt_keeps_slow: assert property (WATCHDOG_ENABLE
        && $past(WATCHDOG_ENABLE) |-> SLOW_OSC_RUN) else $error("slow osc off");
    a_clear_drops_pdf: assert property (
        WATCHDOG_CLEAR_INSTR && CPU_RUN
        && !HALT_INSTR |=> !POWER_DOWN_FLAG) else $error("pdf not cleared");
    a_run_after_ready: assert property ($past(MODE_STATE) == 3'h6
        && MODE_STATE == 3'h0 |-> FAST_OSC_READY) else $error("ran early");
    // an ext reset seen two edges back outranks the overflow
    a_ovf_wake_flag: assert property (
        asleep && WATCHDOG_OVERFLOW && !$past(EXT_RESET_REQ, 2)
        |=> WATCHDOG_TIMEOUT_FLAG && WATCHDOG_RESET) else $error("ovf wake");
    a_ready_needs_osc: assert property (!FAST_OSC_RUN |->
        !FAST_OSC_READY) else $error("ready with osc stopped");
endmodule
bind power_mode_wakeup_control pmw_checker i_pmw_checker (
    .SYS_CLK(SYS_CLK), .RST(RST), .HALT_INSTR(HALT_INSTR),
    .WATCHDOG_CLEAR_INSTR(WATCHDOG_CLEAR_INSTR),
    .WATCHDOG_OVERFLOW(WATCHDOG_OVERFLOW),
    .IDLE_ON_HALT_ENABLE(IDLE_ON_HALT_ENABLE),
    .SYSCLK_KEEP_IN_IDLE(SYSCLK_KEEP_IN_IDLE),
    .WATCHDOG_ENABLE(WATCHDOG_ENABLE), .LVD_ENABLE(LVD_ENABLE),
    .CPU_RUN(CPU_RUN), .SYSCLK_RUN(SYSCLK_RUN), .SUBCLK_RUN(SUBCLK_RUN),
    .SYSCLK_FROM_SLOW(SYSCLK_FROM_SLOW), .FAST_OSC_RUN(FAST_OSC_RUN),
    .FAST_DIV_RUN(FAST_DIV_RUN), .SLOW_OSC_RUN(SLOW_OSC_RUN),
    .FAST_OSC_READY(FAST_OSC_READY), .SLOW_OSC_READY(SLOW_OSC_READY),
    .POWER_DOWN_FLAG(POWER_DOWN_FLAG), .WATCHDOG_CLEAR(WATCHDOG_CLEAR),
    .WATCHDOG_TIMEOUT_FLAG(WATCHDOG_TIMEOUT_FLAG),
    .WATCHDOG_STOP(WATCHDOG_STOP), .WATCHDOG_RESET(WATCHDOG_RESET),
    .EXT_RESET_REQ(EXT_RESET_REQ),
    .MODE_STATE(MODE_STATE));

// >>> dv/power_mode_wakeup_control_tb.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module power_mode_wakeup_control_tb;
    import pwr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, fsel = 1'b1, idle = 1'b0, keep = 1'b0;
    logic wdt = 1'b0, low_voltage_detector = 1'b0, ovf = 1'b0, ext = 1'b0, stk = 1'b0;
    logic hreq = 1'b0, creq = 1'b0, halt, clr, cpu, frdy, srdy, fosc;
    logic fslow, srun, power_down_flag, tof, frst, wrst, isvc;
    logic [2:0] div = 3'h7, mode;
    logic [7:0] pins = 8'hFF, pwe = 8'h00, irq = 8'h00, ien = 8'h00;
    logic [2:0] seen = 3'h0; // sticky record of reset and service pulses
    int err_total = 0, n_compared = 0, cyc = 0;
    always #50 clk = ~clk;
    // pulses stand one cycle, so latch them for the scenario tasks
    always @(posedge clk) seen <= seen | {frst, wrst, isvc};
    power_mode_wakeup_control i_power_mode_wakeup_control (
        .SYS_CLK(clk), .RST(rst), .FAST_CLOCK_SELECT(fsel),
        .CLOCK_DIVIDER_SELECT(div), .IDLE_ON_HALT_ENABLE(idle),
        .SYSCLK_KEEP_IN_IDLE(keep), .WATCHDOG_ENABLE(wdt), .LVD_ENABLE(low_voltage_detector),
        .HALT_INSTR(halt), .WATCHDOG_CLEAR_INSTR(clr),
        .WATCHDOG_OVERFLOW(ovf), .EXT_RESET_REQ(ext), .PORT_PINS(pins),
        .PORT_WAKE_ENABLE(pwe), .IRQ_FLAGS(irq), .IRQ_ENABLES(ien),
        .STACK_FULL(stk), .FAST_OSC_RUN(fosc), .FAST_DIV_RUN(),
        .SLOW_OSC_RUN(), .SYSCLK_FROM_SLOW(fslow), .SYSCLK_RUN(srun),
        .SUBCLK_RUN(), .CPU_RUN(cpu), .FAST_OSC_READY(frdy),
        .SLOW_OSC_READY(srdy), .POWER_DOWN_FLAG(power_down_flag),
        .WATCHDOG_TIMEOUT_FLAG(tof), .WATCHDOG_CLEAR(), .WATCHDOG_STOP(),
        .FULL_RESET(frst), .WATCHDOG_RESET(wrst), .IRQ_SERVICE(isvc),
        .MODE_STATE(mode));
    cpu_core_model i_cpu_core_model (.clk(clk), .cpu_run(cpu),
        .halt_req(hreq), .clr_req(creq), .halt_q(halt), .clr_q(clr));
    task automatic check(input logic [7:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // inputs always move 10 ns after the rising edge
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic wait_mode(input logic [2:0] m, input int lim);
        for (int i = 0; i < lim && mode !== m; i++) step();
    endtask
    // one-cycle request to the core model, then let the mode settle
    task automatic do_halt();
        seen = 3'h0;
        hreq = 1'b1;
        step();
        hreq = 1'b0;
        step(2);
    endtask
    task automatic t_reset();
        step(5);
        rst = 1'b0;
        step();
        // core held off in fast startup until the oscillator is up
        check({mode, power_down_flag, tof, cpu}, {3'h6, 3'b000}, "reset state");
        for (int i = 0; i < 2100 && cpu !== 1'b1; i++) step();
        check(frdy, 1'b1, "fast ready before run");
        for (int i = 0; i < 1100 && srdy !== 1'b1; i++) step();
        check(srdy, 1'b1, "slow ready after fast");
        $display("reset test done");
    endtask
    task automatic t_halt_states();
        for (int k = 0; k < 4; k++) begin
            idle = k[1];
            keep = (k == 3);
            low_voltage_detector  = (k == 1);
            wdt  = (k == 2);
            pwe  = 8'h01 << k;
            do_halt();
            check(mode, 3'h2 + 3'(k), "halt state");
            check({power_down_flag, tof, srun}, {2'b10, keep}, "entry flags");
            pins[k+4] = 1'b0;
            step(10);
            check(mode, 3'h2 + 3'(k), "masked pin woke");
            pins[k] = 1'b0;
            wait_mode(NORMAL_RUN, 2100);
            check({mode, cpu}, 4'h1, "pin wake");
            pins = 8'hFF;
            step(4);
        end
        creq = 1'b1;
        step();
        creq = 1'b0;
        step(2);
        check(power_down_flag, 1'b0, "clear-wdt pdf");
        $display("halt state test done");
    endtask
    task automatic t_slow();
        fsel = 1'b0;
        for (int d = 0; d < 8; d++) begin
            div = 3'(d);
            wait_mode((d < 2) ? SLOW_RUN : NORMAL_RUN, 2100);
            check({mode, fslow, fosc}, {(d < 2) ? 3'h1 : 3'h0,
                d < 2, d >= 2}, "divider mode");
        end
        div = 3'h0;
        step(4);
        fsel = 1'b1;
        wait_mode(NORMAL_RUN, 2100);
        for (int i = 0; i < 2100 && frdy !== 1'b1; i++) step();
        check({mode, frdy}, 4'h1, "back to fast");
        div = 3'h7;
        $display("slow mode test done");
    endtask
    // irq wake: one pending flag at halt, then a fresh one
    task automatic t_irq(input logic en, input logic full);
        {idle, keep, wdt, low_voltage_detector, stk} = {4'hC, full};
        irq = 8'h02;
        // fresh irq on bit 0 carries the enable under test
        ien = {6'h00, 1'b1, en};
        do_halt();
        step(10);
        check(mode, 3'h5, "pending irq woke");
        irq = 8'h03;
        wait_mode(NORMAL_RUN, 20);
        step(2);
        check({mode, seen[0]}, {3'h0, en & !full},
            "irq wake");
        irq = 8'h00;
        stk = 1'b0;
        step(2);
        $display("irq test done");
    endtask
    task automatic t_wdt_ext();
        {idle, wdt} = 2'b01;
        do_halt();
        ovf = 1'b1;
        step();
        ovf = 1'b0;
        step(2);
        check({tof, seen[1]}, 2'b11, "overflow wake");
        wait_mode(NORMAL_RUN, 2100);
        do_halt();
        check(tof, 1'b0, "entry clears timeout");
        ext = 1'b1;
        step(5);
        ext = 1'b0;
        check(seen[2], 1'b1, "ext reset wake");
        wait_mode(NORMAL_RUN, 2100);
        $display("watchdog and reset test done");
    endtask
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        t_reset();
        t_halt_states();
        t_slow();
        t_irq(1'b1, 1'b0);
        t_irq(1'b0, 1'b0);
        t_irq(1'b1, 1'b1);
        t_wdt_ext();
        test_done();
    end
endmodule
